// ==== rtl/rx_poll_params.svh ====
// Register offsets, field positions, reset values and timing counts of the polling timebase
`ifndef RX_POLL_PARAMS_SVH
`define RX_POLL_PARAMS_SVH

// ==========================================
// Register offsets (byte addresses)
`define RP_CTRL_OFS 12'h000
`define RP_BITCHK_OFS 12'h004
`define RP_STATUS_OFS 12'h008

// ==========================================
// Control register fields
`define RP_CTRL_EN_BIT 0
`define RP_CTRL_RANGE_LSB 1
`define RP_CTRL_EXTLIM_BIT 3
`define RP_CTRL_SLEEP_LSB 4
`define RP_CTRL_SLEEPEXT_LSB 9
`define RP_CTRL_RESET 32'h0000_0210

// ==========================================
// Bit-check register fields
`define RP_BC_N_LSB 0
`define RP_BC_MIN_LSB 4
`define RP_BC_MAX_LSB 12
`define RP_BITCHK_RESET 32'h0001_e0a3

// ==========================================
// Status register fields
`define RP_ST_STATE_LSB 0
`define RP_ST_VALID_BIT 3
`define RP_ST_CYCLES_LSB 16

// ==========================================
// Timing, in crystal periods and basic clock periods
`define RP_XTO_PER_DCLK 16
`define RP_SLEEP_UNIT_DCLK 1024
`define RP_PLL_STARTUP_DCLK 798.5
`define RP_PLL_STARTUP_HALF 1597
`define RP_SIGPROC_R0 882
`define RP_SIGPROC_R1 498
`define RP_SIGPROC_R2 306
`define RP_SIGPROC_R3 210

`endif

// ==== rtl/rx_poll_pkg.sv ====
// Types shared by the polling timebase modules
package rx_poll_pkg;

	// ==========================================
	// Polling sequence states, Gray coded along the path from idle through receive
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SLEEP = 3'h1,
		ST_PLL = 3'h3,
		ST_SIGPROC = 3'h2,
		ST_BITCHK = 3'h6,
		ST_RX = 3'h7
	} poll_state_t;

	// ==========================================
	// Configuration written by software
	typedef struct packed {
		logic enable;
		logic [1:0] bit_rate_range;
		logic extended_limit_select;
		logic [4:0] sleep_count;
		logic [2:0] sleep_extension_factor;
		logic [3:0] bitcheck_count;
		logic [7:0] lim_min;
		logic [7:0] lim_max;
	} poll_cfg_t;

	// Clock enables from the timebase divider
	typedef struct packed {
		logic half_en;
		logic dclk_en;
		logic xdclk_en;
	} tick_t;

endpackage

// ==== rtl/rx_poll_divider.sv ====
// Basic and extended digital clock enable divider
`include "rx_poll_params.svh"
module rx_poll_divider import rx_poll_pkg::*; #(
	parameter int DCLK_DIV = `RP_XTO_PER_DCLK
) (
	input wire logic pclk, // Crystal-rate clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic [1:0] bit_rate_range, // Selected bit-rate range
	input wire logic extended_limit_select, // Extended clock limit select
	output tick_t tick // Half, basic and extended clock enables
);
	typedef struct packed {
		logic [7:0] div;
		logic [2:0] xcnt;
		tick_t tick;
	} div_state_t;

	div_state_t s_q, s_d;
	logic [2:0] xdiv;

	// Extended clock period in basic periods, minus one
	function automatic logic [2:0] xdiv_of(input logic [1:0] rng, input logic xl);
		logic [2:0] r;
		r = 3'h7;
		case (rng)
			2'h0: r = 3'h7;
			2'h1: r = 3'h3;
			2'h2: r = xl ? 3'h3 : 3'h1;
			default: r = xl ? 3'h1 : 3'h0;
		endcase
		return r;
	endfunction

	assign xdiv = xdiv_of(bit_rate_range, extended_limit_select);
	assign tick = s_q.tick;

	always_comb begin
		s_d = s_q;
		s_d.tick = '0;
		if (s_q.div == 8'(DCLK_DIV - 1)) begin
			s_d.div = '0;
			s_d.tick.dclk_en = 1'b1;
			s_d.tick.half_en = 1'b1;
			if (s_q.xcnt >= xdiv) begin
				s_d.xcnt = '0;
				s_d.tick.xdclk_en = 1'b1;
			end else begin
				s_d.xcnt = s_q.xcnt + 3'h1;
			end
		end else begin
			s_d.div = s_q.div + 8'h01;
			if (s_q.div == 8'(DCLK_DIV / 2 - 1)) begin
				s_d.tick.half_en = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ==== rtl/rx_polling_timebase.sv ====
// Receive polling timebase with APB configuration and status registers
// Functional notes
// - Basic digital clock period is sixteen crystal periods.
// - Extended clock is 8/4/2/1 basic periods by range; limit select gives 4/2.
// - Sleep lasts sleep count times extension factor times 1024 basic periods.
// - PLL start-up lasts 798.5 basic periods before signal processing.
// - Signal-processing start-up is 882/498/306/210 basic periods by range.
// - Bit check ends after about N signal periods, or at the first data edge for N=0.
// - Bit-rate range selects the supported data rate band.
// - Edge-time limits bound the Manchester edge-to-edge time, up to fifty percent off.
`include "rx_poll_params.svh"
module rx_polling_timebase import rx_poll_pkg::*; #(
	parameter int DCLK_DIV = `RP_XTO_PER_DCLK,
	parameter int SLEEP_UNIT = `RP_SLEEP_UNIT_DCLK,
	parameter int PLL_HALF = `RP_PLL_STARTUP_HALF
) (
	input wire logic pclk, // Crystal-rate clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic data_edge, // One-cycle pulse per demodulated data edge
	output logic pll_on, // PLL start-up or later phase active
	output logic sig_proc_on, // Signal processing active
	output logic signal_valid, // Valid signal found, receive mode
	output poll_state_t poll_state // Current polling phase
);
	typedef struct packed {
		poll_state_t st;
		logic [17:0] cnt;
		logic [10:0] pre;
		logic [9:0] edge_t;
		logic seen_edge;
		logic [3:0] good;
		logic [15:0] cycles;
		poll_cfg_t cfg;
		logic [31:0] rdata;
		logic pll_on;
		logic sig_on;
	} top_state_t;

	top_state_t s_q, s_d;
	tick_t tick;
	logic setup, wr_en;
	logic [7:0] sleep_target;
	logic [9:0] sigproc_len;

	rx_poll_divider #(.DCLK_DIV(DCLK_DIV)) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.bit_rate_range(s_q.cfg.bit_rate_range),
		.extended_limit_select(s_q.cfg.extended_limit_select),
		.tick(tick)
	);

	// ==========================================
	// Decoding
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		logic [1:0] r;
		r = 2'h3;
		if (a == `RP_CTRL_OFS) begin
			r = 2'h0;
		end else if (a == `RP_BITCHK_OFS) begin
			r = 2'h1;
		end else if (a == `RP_STATUS_OFS) begin
			r = 2'h2;
		end
		return r;
	endfunction

	function automatic logic [9:0] sigproc_of(input logic [1:0] rng);
		logic [9:0] r;
		r = 10'(`RP_SIGPROC_R0);
		case (rng)
			2'h0: r = 10'(`RP_SIGPROC_R0);
			2'h1: r = 10'(`RP_SIGPROC_R1);
			2'h2: r = 10'(`RP_SIGPROC_R2);
			default: r = 10'(`RP_SIGPROC_R3);
		endcase
		return r;
	endfunction

	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (reg_sel(paddr) == 2'h3);
	assign prdata = s_q.rdata;
	assign pll_on = s_q.pll_on;
	assign sig_proc_on = s_q.sig_on;
	assign signal_valid = (s_q.st == ST_RX);
	assign poll_state = s_q.st;
	assign sleep_target = 8'(s_q.cfg.sleep_count) * 8'(s_q.cfg.sleep_extension_factor);
	assign sigproc_len = sigproc_of(s_q.cfg.bit_rate_range);

	always_comb begin
		s_d = s_q;
		// ==========================================
		// APB register access
		if (setup) begin
			s_d.rdata = '0;
			case (reg_sel(paddr))
				2'h0: begin
					s_d.rdata[`RP_CTRL_EN_BIT] = s_q.cfg.enable;
					s_d.rdata[`RP_CTRL_RANGE_LSB +: 2] = s_q.cfg.bit_rate_range;
					s_d.rdata[`RP_CTRL_EXTLIM_BIT] = s_q.cfg.extended_limit_select;
					s_d.rdata[`RP_CTRL_SLEEP_LSB +: 5] = s_q.cfg.sleep_count;
					s_d.rdata[`RP_CTRL_SLEEPEXT_LSB +: 3] = s_q.cfg.sleep_extension_factor;
				end
				2'h1: begin
					s_d.rdata[`RP_BC_N_LSB +: 4] = s_q.cfg.bitcheck_count;
					s_d.rdata[`RP_BC_MIN_LSB +: 8] = s_q.cfg.lim_min;
					s_d.rdata[`RP_BC_MAX_LSB +: 8] = s_q.cfg.lim_max;
				end
				2'h2: begin
					s_d.rdata[`RP_ST_STATE_LSB +: 3] = s_q.st;
					s_d.rdata[`RP_ST_VALID_BIT] = (s_q.st == ST_RX);
					s_d.rdata[`RP_ST_CYCLES_LSB +: 16] = s_q.cycles;
				end
				default: s_d.rdata = '0;
			endcase
		end
		if (wr_en && reg_sel(paddr) == 2'h0) begin
			s_d.cfg.enable = pwdata[`RP_CTRL_EN_BIT];
			s_d.cfg.bit_rate_range = pwdata[`RP_CTRL_RANGE_LSB +: 2];
			s_d.cfg.extended_limit_select = pwdata[`RP_CTRL_EXTLIM_BIT];
			s_d.cfg.sleep_count = pwdata[`RP_CTRL_SLEEP_LSB +: 5];
			s_d.cfg.sleep_extension_factor = pwdata[`RP_CTRL_SLEEPEXT_LSB +: 3];
		end else if (wr_en && reg_sel(paddr) == 2'h1) begin
			s_d.cfg.bitcheck_count = pwdata[`RP_BC_N_LSB +: 4];
			s_d.cfg.lim_min = pwdata[`RP_BC_MIN_LSB +: 8];
			s_d.cfg.lim_max = pwdata[`RP_BC_MAX_LSB +: 8];
		end

		// ==========================================
		// Polling sequence
		case (s_q.st)
			ST_IDLE: begin
				s_d.cnt = '0;
				s_d.pre = '0;
				if (s_q.cfg.enable) begin
					s_d.st = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				// Leave on a basic tick: sleep never ends short and PLL start-up begins on a tick
				if (tick.dclk_en && s_q.cnt >= 18'(sleep_target)) begin
					s_d.st = ST_PLL;
					s_d.cnt = '0;
					s_d.pre = '0;
					s_d.pll_on = 1'b1;
				end else if (tick.dclk_en) begin
					if (s_q.pre == 11'(SLEEP_UNIT - 1)) begin
						s_d.pre = '0;
						s_d.cnt = s_q.cnt + 18'h1;
					end else begin
						s_d.pre = s_q.pre + 11'h1;
					end
				end
			end
			ST_PLL: begin
				if (tick.half_en) begin
					if (s_q.cnt == 18'(PLL_HALF - 1)) begin
						s_d.st = ST_SIGPROC;
						s_d.cnt = '0;
						s_d.sig_on = 1'b1;
					end else begin
						s_d.cnt = s_q.cnt + 18'h1;
					end
				end
			end
			ST_SIGPROC: begin
				// Counted in half periods, as this phase starts on a half-period boundary
				if (tick.half_en) begin
					if (s_q.cnt == 18'({sigproc_len, 1'b0}) - 18'h1) begin
						s_d.st = ST_BITCHK;
						s_d.cnt = '0;
						s_d.edge_t = '0;
						s_d.seen_edge = 1'b0;
						s_d.good = '0;
					end else begin
						s_d.cnt = s_q.cnt + 18'h1;
					end
				end
			end
			ST_BITCHK: begin
				if (tick.xdclk_en) begin
					s_d.edge_t = s_q.edge_t + 10'h1;
				end
				if (data_edge) begin
					s_d.edge_t = '0;
					s_d.seen_edge = 1'b1;
					if (s_q.cfg.bitcheck_count == 4'h0) begin
						s_d.st = ST_RX;
					end else if (s_q.seen_edge && s_q.edge_t < 10'(s_q.cfg.lim_min)) begin
						s_d.st = ST_SLEEP;
					end else if (s_q.seen_edge) begin
						s_d.good = s_q.good + 4'h1;
						if (s_q.good + 4'h1 >= s_q.cfg.bitcheck_count) begin
							s_d.st = ST_RX;
						end
					end
				end else if (s_q.edge_t > 10'(s_q.cfg.lim_max)) begin
					s_d.st = ST_SLEEP;
				end
				if (s_d.st == ST_SLEEP) begin
					s_d.cnt = '0;
					s_d.pre = '0;
					s_d.pll_on = 1'b0;
					s_d.sig_on = 1'b0;
					s_d.cycles = s_q.cycles + 16'h1;
				end
			end
			ST_RX: begin
				s_d.st = ST_RX;
			end
			default: s_d.st = ST_IDLE;
		endcase
		if (!s_d.cfg.enable) begin
			s_d.st = ST_IDLE;
			s_d.pll_on = 1'b0;
			s_d.sig_on = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.cfg.sleep_count <= 5'(`RP_CTRL_RESET >> `RP_CTRL_SLEEP_LSB);
			s_q.cfg.sleep_extension_factor <= 3'(`RP_CTRL_RESET >> `RP_CTRL_SLEEPEXT_LSB);
			s_q.cfg.bitcheck_count <= 4'(`RP_BITCHK_RESET >> `RP_BC_N_LSB);
			s_q.cfg.lim_min <= 8'(`RP_BITCHK_RESET >> `RP_BC_MIN_LSB);
			s_q.cfg.lim_max <= 8'(`RP_BITCHK_RESET >> `RP_BC_MAX_LSB);
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ==== test/rx_poll_sva.sv ====
// Port assertions for the polling timebase
module rx_poll_sva import rx_poll_pkg::*; #(
	parameter int DCLK_DIV = 16,
	parameter int PLL_HALF = 1597
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] prdata, // APB read data
	input wire logic pslverr, // APB error
	input wire logic pll_on, // PLL phase flag
	input wire logic sig_proc_on, // Signal processing flag
	input wire logic signal_valid, // Valid signal flag
	input wire poll_state_t poll_state // Polling phase
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PLL_MIN = PLL_HALF * DCLK_DIV / 2 - 1;
	localparam int PLL_MAX = PLL_HALF * DCLK_DIV / 2 + DCLK_DIV;
	int pll_cnt_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// Cycles spent in PLL start-up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_cnt_q <= 0;
		end else begin
			pll_cnt_q <= (poll_state == ST_PLL) ? pll_cnt_q + 1 : 0;
		end
	end
	sleep_next_a: assert property (poll_state == ST_SLEEP |=> poll_state inside {ST_SLEEP, ST_PLL, ST_IDLE})
		else $error("bad exit from sleep");
	pll_next_a: assert property (poll_state == ST_PLL |=> poll_state inside {ST_PLL, ST_SIGPROC, ST_IDLE})
		else $error("bad exit from pll");
	sigproc_next_a: assert property (poll_state == ST_SIGPROC |=> poll_state inside {ST_SIGPROC, ST_BITCHK, ST_IDLE})
		else $error("bad exit from sigproc");
	bitchk_next_a: assert property (poll_state == ST_BITCHK |=> poll_state != ST_PLL && poll_state != ST_SIGPROC)
		else $error("bad exit from bit check");
	pll_length_a: assert property ($past(poll_state) == ST_PLL && poll_state == ST_SIGPROC
		|-> pll_cnt_q >= PLL_MIN && pll_cnt_q <= PLL_MAX)
		else $error("pll start-up length wrong");
	valid_rx_a: assert property ((signal_valid == (poll_state == ST_RX)) && (!signal_valid || (pll_on && sig_proc_on)))
		else $error("valid flag disagrees with state or flags");
	sigproc_flags_a: assert property ((poll_state == ST_SIGPROC) [*2] |-> pll_on && sig_proc_on)
		else $error("flags low in sigproc");
	sleep_flags_a: assert property ((poll_state == ST_SLEEP) [*2] |-> !pll_on && !sig_proc_on)
		else $error("flags high in sleep");
	unmapped_err_a: assert property (psel && penable && !(paddr inside {12'h000, 12'h004, 12'h008})
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
endmodule

bind rx_polling_timebase rx_poll_sva #(.DCLK_DIV(DCLK_DIV), .PLL_HALF(PLL_HALF)) u_rx_poll_sva (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pslverr(pslverr), .pll_on(pll_on), .sig_proc_on(sig_proc_on), .signal_valid(signal_valid),
	.poll_state(poll_state));

// ==== test/rx_poll_host.sv ====
// Host model that writes and reads configuration over APB
module rx_poll_host (
	input wire logic pclk, // Clock
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	output logic psel, // Select
	output logic penable, // Enable
	output logic pwrite, // Write
	output logic [11:0] paddr, // Address
	output logic [31:0] pwdata // Write data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// One transfer; ok stays low if the slave never answers
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err, output logic ok);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		ok = (pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ==== test/rx_polling_timebase_tb.sv ====
// Self-checking bench for the polling timebase
module rx_polling_timebase_tb import rx_poll_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic data_edge = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, pll_on, sig_proc_on, signal_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	poll_state_t poll_state;
	int failures = 0;
	int checks_done = 0;
	always #20 pclk = ~pclk;
	rx_poll_host u_rx_poll_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	rx_polling_timebase #(.DCLK_DIV(DIV), .SLEEP_UNIT(4), .PLL_HALF(5)) u_rx_polling_timebase (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .data_edge(data_edge), .pll_on(pll_on),
		.sig_proc_on(sig_proc_on), .signal_valid(signal_valid), .poll_state(poll_state));
	// ==========================================
	// Checking and closing
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd, output logic err);
		logic ok;
		u_rx_poll_host.xfer(wr, a, wd, rd, err, ok);
		check("apb answer", ok, 1'b1);
		if (ok !== 1'b1) summarize();
	endtask
	// Counts cycles spent in one phase
	task automatic span(poll_state_t st, output int n);
		n = 0;
		while (poll_state === st && n < 5000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 5000) begin
			check("phase hang", 0, 1);
			summarize();
		end
	endtask
	task automatic pulse(int gap);
		repeat (gap) @(posedge pclk);
		data_edge <= 1'b1;
		@(posedge pclk);
		data_edge <= 1'b0;
	endtask
	function automatic int sp_len(logic [1:0] r);
		return DIV * (r == 0 ? 882 : r == 1 ? 498 : r == 2 ? 306 : 210);
	endfunction
	function automatic int ext(logic [1:0] r, logic x);
		return DIV * ((x && r[1]) ? (r == 2 ? 4 : 2) : (8 >> r));
	endfunction
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] rd;
		logic err, x;
		logic [1:0] r;
		int n, s, xs, e, nfail;
		void'($urandom(32'h544aaa08));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h000, 0, rd, err);
		check("ctrl reset", rd, 32'h0000_0210);
		apb(0, 12'h004, 0, rd, err);
		check("bitchk reset", rd, 32'h0001_e0a3);
		apb(1, 12'h00c, 32'hffff_ffff, rd, err);
		check("unmapped write", err, 1);
		apb(0, 12'h00c, 0, rd, err);
		check("unmapped read", rd, 0);
		for (int i = 0; i < 8; i++) begin
			r = i[1:0];
			x = i[2];
			s = $urandom_range(3, 1);
			xs = $urandom_range(2, 1);
			e = ext(r, x);
			if (i == 7) begin
				apb(1, 12'h004, 32'h0001_e0a0, rd, err);
				apb(0, 12'h004, 0, rd, err);
				check("bitchk write", rd, 32'h0001_e0a0);
			end
			apb(1, 12'h000, {20'h0, xs[2:0], s[4:0], x, r, 1'b1}, rd, err);
			@(negedge pclk);
			span(ST_IDLE, n);
			span(ST_SLEEP, n);
			check("sleep len", n >= s * xs * 4 * DIV && n <= s * xs * 4 * DIV + DIV, 1);
			span(ST_PLL, n);
			check("pll len", n >= 10 && n <= 10 + DIV, 1);
			span(ST_SIGPROC, n);
			check("sigproc len", n >= sp_len(r) && n <= sp_len(r) + DIV, 1);
			check("bitchk entry", poll_state, ST_BITCHK);
			if (i[0]) begin
				pulse(5);
				if (i == 5) begin
					pulse(5 * e - 1);
					repeat (2) @(negedge pclk);
					check("early edge", poll_state, ST_SLEEP);
					nfail++;
				end else begin
					if (i != 7) repeat (3) pulse($urandom_range(26, 14) * e - 1);
					repeat (2) @(negedge pclk);
					check("rx reached", poll_state, ST_RX);
					check("valid flag", signal_valid, 1);
				end
			end else begin
				span(ST_BITCHK, n);
				check("timeout len", n >= 30 * e && n <= 32 * e + DIV, 1);
				nfail++;
				apb(0, 12'h008, 0, rd, err);
				check("back to sleep", rd[3:0], 4'h1);
				check("fail count", rd[31:16], nfail);
			end
			apb(1, 12'h000, 0, rd, err);
			repeat (2) @(negedge pclk);
			check("idle", poll_state, ST_IDLE);
		end
		summarize();
	end
endmodule
